// *** hw/tcu_pkg.sv ***
// Function
// - compare value checked against timer every cycle
// - match sets, clears or keeps compare pin
// - match sets compare flag on the next clock
// - zero write to control clears output latch
// - config bit 12 routes pin to bit 0/3
// - interrupt-only mode leaves pin untouched
// - special trigger clears timer, starts conversion
// - special trigger reset never sets overflow flag
// - timer counts up, wraps, sets overflow flag
// - internal mode advances once per instruction cycle at prescale 1:1
// - timer runs only while run bit set
package tcu_pkg;

  // bus geometry
  localparam int unsigned ADDR_W      = 12;           // byte address width
  localparam int unsigned DATA_W      = 32;           // bus data width
  localparam int unsigned IDX_W       = 10;           // register index width

  // register indices, byte address is four times the index
  localparam logic [9:0]  IDX_INTCTL  = 10'h00b;      // interrupt_control
  localparam logic [9:0]  IDX_PFLAG   = 10'h00c;      // peripheral_flags_one
  localparam logic [9:0]  IDX_CNT_LO  = 10'h00e;      // timer_count_low
  localparam logic [9:0]  IDX_CNT_HI  = 10'h00f;      // timer_count_high
  localparam logic [9:0]  IDX_TCTL    = 10'h010;      // timer_control
  localparam logic [9:0]  IDX_CMP_LO  = 10'h015;      // compare_value_low
  localparam logic [9:0]  IDX_CMP_HI  = 10'h016;      // compare_value_high
  localparam logic [9:0]  IDX_CCTL    = 10'h017;      // compare_control
  localparam logic [9:0]  IDX_PDIR    = 10'h086;      // port_b_direction
  localparam logic [9:0]  IDX_PIE     = 10'h08c;      // peripheral_enables_one
  localparam logic [9:0]  IDX_CFG     = 10'h0a0;      // configuration word copy

  // field positions
  localparam int unsigned FLG_OVF     = 0;            // timer_overflow_flag / enable
  localparam int unsigned FLG_CMP     = 2;            // compare_irq_flag / enable
  localparam int unsigned TCTL_RUN    = 0;            // timer_run_enable
  localparam int unsigned TCTL_SRC    = 1;            // timer_source_select
  localparam int unsigned TCTL_PS     = 4;            // prescale field, two bits
  localparam int unsigned CFG_PINSEL  = 12;           // compare_pin_select_config
  localparam int unsigned PIN_A       = 0;            // port bit used when select set
  localparam int unsigned PIN_B       = 3;            // port bit used when select clear

  // reset values
  localparam logic [7:0]  RST_INTCTL  = 8'h00;
  localparam logic [7:0]  RST_PFLAG   = 8'h00;
  localparam logic [15:0] RST_COUNT   = 16'h0000;
  localparam logic [7:0]  RST_TCTL    = 8'h00;
  localparam logic [15:0] RST_CMPV    = 16'h0000;
  localparam logic [7:0]  RST_CCTL    = 8'h00;
  localparam logic [7:0]  RST_PDIR    = 8'hff;
  localparam logic [7:0]  RST_PIE     = 8'h00;
  localparam logic [15:0] RST_CFG     = 16'h0000;

  // compare_mode_bits encodings
  localparam logic [3:0]  MODE_SET    = 4'h8;         // drive pin high on match
  localparam logic [3:0]  MODE_CLR    = 4'h9;         // drive pin low on match
  localparam logic [3:0]  MODE_SWI    = 4'ha;         // interrupt only
  localparam logic [3:0]  MODE_SEV    = 4'hb;         // special event trigger

  // timing: instruction cycle is four system clocks
  localparam int unsigned INSTR_DIV   = 4;
  localparam logic [15:0] COUNT_MAX   = 16'hffff;

  // apb request bundle from the master
  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } tcu_apb_req_type;

endpackage

// *** hw/tcu_sync2.sv ***
`timescale 1ns/1ps
// two flip-flop synchroniser for a level from outside the clock domain
module tcu_sync2
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // level in and out
  input  wire logic async_i,
  output logic      sync_o
);
  import tcu_pkg::*;

  logic meta_q;                               // first stage, read only by second
  logic sync_q;                               // second stage

  // shift the level through two stages
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end
    else
    begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;
endmodule

// *** hw/tcu_tick.sv ***
`timescale 1ns/1ps
// timer count enable: instruction divider, external edge, prescaler
module tcu_tick
#(
  parameter int unsigned DIV = tcu_pkg::INSTR_DIV
)
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // control
  input  wire logic       ext_sync_i,
  input  wire logic       run_i,
  input  wire logic       src_ext_i,
  input  wire logic [1:0] prescale_i,
  // enable pulse
  output logic            count_en_o
);
  import tcu_pkg::*;

  logic [7:0] div_q, div_d;                   // instruction cycle divider
  logic       ext_prev_q;                     // external level last cycle
  logic [2:0] ps_q, ps_d;                     // prescale counter
  logic       src_tick;                       // one source event
  logic [2:0] ps_lim;                         // prescale ratio minus one
  logic       fire;                           // prescaled pulse

  // next values for divider and prescaler
  always_comb
  begin
    div_d    = (div_q == 8'(DIV - 1)) ? 8'h00 : div_q + 8'h01;
    // external rising edge or internal instruction cycle
    src_tick = src_ext_i ? (ext_sync_i & ~ext_prev_q) : (div_q == 8'(DIV - 1));
    ps_lim   = 3'((4'h1 << prescale_i) - 4'h1);
    fire     = run_i & src_tick & (ps_q == ps_lim);
    ps_d     = ps_q;
    if (!run_i)
    begin
      ps_d = 3'h0;                            // stopped timer restarts prescale
    end
    else if (src_tick)
    begin
      ps_d = fire ? 3'h0 : ps_q + 3'h1;
    end
  end

  // register the divider state
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      div_q      <= 8'h00;
      ext_prev_q <= 1'b0;
      ps_q       <= 3'h0;
    end
    else
    begin
      div_q      <= div_d;
      ext_prev_q <= ext_sync_i;
      ps_q       <= ps_d;
    end
  end

  assign count_en_o = fire;
endmodule

// *** hw/tcu_top.sv ***
`timescale 1ns/1ps
// timer with compare unit behind an apb slave
module tcu_top
(
  // clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    rst_n_i,
  // apb slave
  input  wire tcu_pkg::tcu_apb_req_type apb_i,
  output logic                         pready_o,
  output logic [tcu_pkg::DATA_W-1:0]   prdata_o,
  output logic                         pslverr_o,
  // timer external clock pin
  input  wire logic                    ext_clk_i,
  // converter side
  input  wire logic                    adc_enable_i,
  output logic                         adc_start_o,
  // compare output on port bits 0 and 3
  output logic                         pin0_o,
  output logic                         pin0_oe_n_o,
  output logic                         pin3_o,
  output logic                         pin3_oe_n_o,
  // interrupt request level
  output logic                         irq_request_o
);
  import tcu_pkg::*;

  // index match on a word address
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [IDX_W-1:0] idx);
    hit = (a[ADDR_W-1:2] == idx);
  endfunction

  logic [7:0]  intctl_q, intctl_d;            // interrupt_control storage
  logic        ovf_q, ovf_d;                  // timer_overflow_flag
  logic        cmpf_q, cmpf_d;                // compare_irq_flag
  logic [15:0] count_q, count_d;              // timer_count
  logic [5:0]  tctl_q, tctl_d;                // timer_control bits 5:0
  logic [15:0] cmpv_q, cmpv_d;                // compare_value
  logic [5:0]  cctl_q, cctl_d;                // compare_control bits 5:0
  logic [7:0]  pdir_q, pdir_d;                // port_b_direction
  logic [7:0]  pie_q, pie_d;                  // peripheral_enables_one
  logic [15:0] cfg_q, cfg_d;                  // configuration word
  logic        latch_q, latch_d;              // compare output latch
  logic        eq_prev_q, eq_prev_d;          // equality seen last cycle
  logic        adc_q, adc_d;                  // conversion start pulse
  logic [31:0] rdata_q, rdata_d;              // read data register
  logic        acc, wr, rd_setup, mapped;     // bus phase decode
  logic [31:0] rmux;                          // read selection
  logic [7:0]  wb;                            // low write byte
  logic        ext_sync;                      // synchronised timer clock pin
  logic        cnt_en;                        // timer advance pulse
  logic [3:0]  mode;                          // compare_mode_bits
  logic        cmp_on;                        // valid compare mode selected
  logic        eq;                            // timer equals compare value
  logic        match;                         // first cycle of equality
  logic        sev;                           // special event trigger
  logic        ovf_set;                       // wrap event
  logic        cctl_zero_wr;                  // whole control written zero
  logic        sel_a;                         // compare on pin bit 0

  // timer clock pin crossing
  tcu_sync2 u_sync
  (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .async_i (ext_clk_i),
    .sync_o  (ext_sync)
  );

  // count enable generation
  tcu_tick #(.DIV(INSTR_DIV)) u_tick
  (
    .clk_i      (clk_i),
    .rst_n_i    (rst_n_i),
    .ext_sync_i (ext_sync),
    .run_i      (tctl_q[TCTL_RUN]),
    .src_ext_i  (tctl_q[TCTL_SRC]),
    .prescale_i (tctl_q[TCTL_PS+1:TCTL_PS]),
    .count_en_o (cnt_en)
  );

  // bus decode and read mux
  always_comb
  begin
    acc      = apb_i.psel & apb_i.penable;
    wr       = acc & apb_i.pwrite;
    rd_setup = apb_i.psel & ~apb_i.penable & ~apb_i.pwrite;
    wb       = apb_i.pwdata[7:0];
    mapped   = hit(apb_i.paddr, IDX_INTCTL) | hit(apb_i.paddr, IDX_PFLAG)
             | hit(apb_i.paddr, IDX_CNT_LO) | hit(apb_i.paddr, IDX_CNT_HI)
             | hit(apb_i.paddr, IDX_TCTL)   | hit(apb_i.paddr, IDX_CMP_LO)
             | hit(apb_i.paddr, IDX_CMP_HI) | hit(apb_i.paddr, IDX_CCTL)
             | hit(apb_i.paddr, IDX_PDIR)   | hit(apb_i.paddr, IDX_PIE)
             | hit(apb_i.paddr, IDX_CFG);
    rmux = 32'h0000_0000;                     // unmapped and reserved read zero
    if (hit(apb_i.paddr, IDX_INTCTL))
      rmux[7:0] = intctl_q;
    if (hit(apb_i.paddr, IDX_PFLAG))
    begin
      rmux[FLG_OVF] = ovf_q;
      rmux[FLG_CMP] = cmpf_q;
    end
    if (hit(apb_i.paddr, IDX_CNT_LO))
      rmux[7:0] = count_q[7:0];
    if (hit(apb_i.paddr, IDX_CNT_HI))
      rmux[7:0] = count_q[15:8];
    if (hit(apb_i.paddr, IDX_TCTL))
      rmux[5:0] = tctl_q;
    if (hit(apb_i.paddr, IDX_CMP_LO))
      rmux[7:0] = cmpv_q[7:0];
    if (hit(apb_i.paddr, IDX_CMP_HI))
      rmux[7:0] = cmpv_q[15:8];
    if (hit(apb_i.paddr, IDX_CCTL))
      rmux[5:0] = cctl_q;
    if (hit(apb_i.paddr, IDX_PDIR))
      rmux[7:0] = pdir_q;
    if (hit(apb_i.paddr, IDX_PIE))
      rmux[7:0] = pie_q;
    if (hit(apb_i.paddr, IDX_CFG))
      rmux[15:0] = cfg_q;
  end

  // compare detection
  // equality is remembered so a long match fires only once
  always_comb
  begin
    mode      = cctl_q[3:0];
    cmp_on    = (mode == MODE_SET) | (mode == MODE_CLR)
              | (mode == MODE_SWI) | (mode == MODE_SEV);
    eq        = (count_q == cmpv_q);
    eq_prev_d = cmp_on & eq;
    match     = cmp_on & eq & ~eq_prev_q;
    sev       = match & (mode == MODE_SEV);
    adc_d     = sev & adc_enable_i;
  end

  // next register values
  always_comb
  begin
    intctl_d     = intctl_q;
    tctl_d       = tctl_q;
    cmpv_d       = cmpv_q;
    cctl_d       = cctl_q;
    pdir_d       = pdir_q;
    pie_d        = pie_q;
    cfg_d        = cfg_q;
    count_d      = count_q;
    ovf_set      = 1'b0;
    cctl_zero_wr = wr & hit(apb_i.paddr, IDX_CCTL) & (wb == 8'h00);
    rdata_d      = rd_setup ? rmux : rdata_q;
    // timer advance and wrap
    // a wrap that meets a special trigger raises no flag
    if (cnt_en)
    begin
      count_d = count_q + 16'h0001;
      ovf_set = (count_q == COUNT_MAX) & ~sev;
    end
    // software writes
    // a timer byte write beats the increment of the same cycle
    if (wr && hit(apb_i.paddr, IDX_INTCTL))
      intctl_d = wb;
    if (wr && hit(apb_i.paddr, IDX_CNT_LO))
      count_d[7:0] = wb;
    if (wr && hit(apb_i.paddr, IDX_CNT_HI))
      count_d[15:8] = wb;
    if (wr && hit(apb_i.paddr, IDX_TCTL))
      tctl_d = wb[5:0];
    if (wr && hit(apb_i.paddr, IDX_CMP_LO))
      cmpv_d[7:0] = wb;
    if (wr && hit(apb_i.paddr, IDX_CMP_HI))
      cmpv_d[15:8] = wb;
    if (wr && hit(apb_i.paddr, IDX_CCTL))
      cctl_d = wb[5:0];
    if (wr && hit(apb_i.paddr, IDX_PDIR))
      pdir_d = wb;
    if (wr && hit(apb_i.paddr, IDX_PIE))
      pie_d = wb;
    if (wr && hit(apb_i.paddr, IDX_CFG))
      cfg_d = apb_i.pwdata[15:0];
    // special event clears both bytes, beating any write
    if (sev)
      count_d = 16'h0000;
    // flags: hardware set wins over software clear
    // writing a one sets a flag, writing a zero clears it
    ovf_d  = ((wr && hit(apb_i.paddr, IDX_PFLAG)) ? wb[FLG_OVF] : ovf_q) | ovf_set;
    cmpf_d = ((wr && hit(apb_i.paddr, IDX_PFLAG)) ? wb[FLG_CMP] : cmpf_q) | match;
    // compare output latch
    latch_d = latch_q;
    if (cctl_zero_wr)
      latch_d = 1'b0;
    else if (match && mode == MODE_SET)
      latch_d = 1'b1;
    else if (match && mode == MODE_CLR)
      latch_d = 1'b0;
  end

  // register all state
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      intctl_q  <= RST_INTCTL;
      ovf_q     <= RST_PFLAG[FLG_OVF];
      cmpf_q    <= RST_PFLAG[FLG_CMP];
      count_q   <= RST_COUNT;
      tctl_q    <= RST_TCTL[5:0];
      cmpv_q    <= RST_CMPV;
      cctl_q    <= RST_CCTL[5:0];
      pdir_q    <= RST_PDIR;
      pie_q     <= RST_PIE;
      cfg_q     <= RST_CFG;
      latch_q   <= 1'b0;
      eq_prev_q <= 1'b0;
      adc_q     <= 1'b0;
      rdata_q   <= 32'h0000_0000;
    end
    else
    begin
      intctl_q  <= intctl_d;
      ovf_q     <= ovf_d;
      cmpf_q    <= cmpf_d;
      count_q   <= count_d;
      tctl_q    <= tctl_d;
      cmpv_q    <= cmpv_d;
      cctl_q    <= cctl_d;
      pdir_q    <= pdir_d;
      pie_q     <= pie_d;
      cfg_q     <= cfg_d;
      latch_q   <= latch_d;
      eq_prev_q <= eq_prev_d;
      adc_q     <= adc_d;
      rdata_q   <= rdata_d;
    end
  end

  // outputs: pin routing follows config bit, drive only when direction bit clear
  assign sel_a         = cfg_q[CFG_PINSEL];
  assign pin0_o        = sel_a & latch_q;
  assign pin0_oe_n_o   = ~(sel_a & cmp_on) | pdir_q[PIN_A];
  assign pin3_o        = ~sel_a & latch_q;
  assign pin3_oe_n_o   = ~(~sel_a & cmp_on) | pdir_q[PIN_B];
  assign adc_start_o   = adc_q;
  assign irq_request_o = (cmpf_q & pie_q[FLG_CMP]) | (ovf_q & pie_q[FLG_OVF]);
  assign pready_o      = 1'b1;                                                 // zero wait states
  assign prdata_o      = rdata_q;
  assign pslverr_o     = acc & ~mapped;

  // assertions share the system clock and reset
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // compare actions
  cmp_flag_set_a: assert property (match |=> cmpf_q)
    else $error("compare flag not set after match");
  pin_high_a: assert property (match && mode == MODE_SET && !cctl_zero_wr |=> latch_q)
    else $error("set mode did not raise latch");
  pin_low_a: assert property (match && mode == MODE_CLR |=> !latch_q)
    else $error("clear mode did not lower latch");
  swi_pin_hold_a: assert property (match && mode == MODE_SWI && !cctl_zero_wr |=> $stable(latch_q))
    else $error("interrupt-only mode changed latch");
  sev_timer_clear_a: assert property (sev |=> count_q == 16'h0000 ##1 count_q <= 16'h0001)
    else $error("special trigger did not clear timer");
  sev_adc_start_a: assert property (sev && adc_enable_i |=> adc_start_o ##1 !adc_start_o)
    else $error("special trigger did not start conversion");
  sev_no_ovf_a: assert property (sev && !(wr && hit(apb_i.paddr, IDX_PFLAG)) |=> ovf_q == $past(ovf_q))
    else $error("special trigger touched overflow flag");
  clear_latch_a: assert property (cctl_zero_wr |=> !latch_q && mode == 4'h0)
    else $error("zero control write left latch high");
  wrap_ovf_a: assert property (cnt_en && count_q == COUNT_MAX && !sev && !wr |=> count_q == 16'h0000 && ovf_q)
    else $error("wrap did not set overflow");
  timer_hold_a: assert property (!tctl_q[TCTL_RUN] && !wr && !sev |=> $stable(count_q))
    else $error("stopped timer moved");
  match_once_a: assert property (match ##1 (cmp_on && eq) |-> !match)
    else $error("match fired twice on one equality");
  route_a: assert property (sel_a |-> pin3_oe_n_o && !pin3_o)
    else $error("compare output on unselected pin");

  // timer, flags and pulse housekeeping
  adc_pulse_only_a: assert property (!sev |=> !adc_start_o)
    else $error("conversion start without special trigger");
  count_step_a: assert property (cnt_en && !wr && !sev |=> count_q == $past(count_q) + 16'h0001)
    else $error("timer did not advance by one");
  run_gate_a: assert property (cnt_en |-> tctl_q[TCTL_RUN])
    else $error("timer advanced while stopped");
  ovf_wrap_only_a: assert property (!ovf_q && !(wr && hit(apb_i.paddr, IDX_PFLAG))
    && !(cnt_en && count_q == COUNT_MAX) |=> !ovf_q)
    else $error("overflow flag set without wrap");
  cmp_flag_keep_a: assert property (cmpf_q && !(wr && hit(apb_i.paddr, IDX_PFLAG)) |=> cmpf_q)
    else $error("compare flag dropped without clear");
  ovf_flag_keep_a: assert property (ovf_q && !(wr && hit(apb_i.paddr, IDX_PFLAG)) |=> ovf_q)
    else $error("overflow flag dropped without clear");

  // pins and interrupt request
  latch_steady_a: assert property (!match && !cctl_zero_wr |=> $stable(latch_q))
    else $error("latch moved without match");
  pins_released_a: assert property (!cmp_on |-> pin0_oe_n_o && pin3_oe_n_o)
    else $error("pin driven with compare off");
  irq_on_match_a: assert property (match && pie_q[FLG_CMP] && !wr |=> irq_request_o)
    else $error("enabled compare raised no request");
  irq_masked_a: assert property (!pie_q[FLG_CMP] && !pie_q[FLG_OVF] |-> !irq_request_o)
    else $error("masked flags raised a request");
endmodule

// *** verif/tcu_far_model.sv ***
`timescale 1ns/1ps
// far side: converter start counter and pulled-down port pads
module tcu_far_model
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // converter side
  output logic       adc_enable_o,
  input  wire logic adc_start_i,
  output logic [7:0] starts_o,
  // port pins from the block
  input  wire logic pin0_i,
  input  wire logic pin0_oe_n_i,
  input  wire logic pin3_i,
  input  wire logic pin3_oe_n_i,
  // resolved pad levels
  output logic       pad0_o,
  output logic       pad3_o
);
  // converter stays enabled so every trigger must start it
  assign adc_enable_o = 1'b1;
  // count one-cycle start pulses
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      starts_o <= 8'h00;
    else if (adc_start_i)
      starts_o <= starts_o + 8'h01;
  end
  // released pads fall to the board pull-down
  assign pad0_o = pin0_oe_n_i ? 1'b0 : pin0_i;
  assign pad3_o = pin3_oe_n_i ? 1'b0 : pin3_i;
endmodule

// *** verif/testbench.sv ***
`timescale 1ns/1ps
// register-level bench for the timer compare unit
module testbench;
  import tcu_pkg::*;
  logic              clk_i;
  logic              rst_n_i;
  tcu_apb_req_type   apb;
  logic              pready, pslverr, adc_en, adc_start;
  logic              p0, p0n, p3, p3n, irq, pad0, pad3;
  logic [DATA_W-1:0] prdata, rd;
  logic              err;
  logic              ext_clk;
  logic [7:0]        starts;
  logic [3:0]        modes [5];
  logic              lvl [5];
  int                failures, tests_run;

  // block under test, external count pin driven by the bench
  tcu_top DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .apb_i(apb), .pready_o(pready),
    .prdata_o(prdata), .pslverr_o(pslverr), .ext_clk_i(ext_clk), .adc_enable_i(adc_en),
    .adc_start_o(adc_start), .pin0_o(p0), .pin0_oe_n_o(p0n), .pin3_o(p3),
    .pin3_oe_n_o(p3n), .irq_request_o(irq));

  // far side
  tcu_far_model far (.clk_i(clk_i), .rst_n_i(rst_n_i), .adc_enable_o(adc_en),
    .adc_start_i(adc_start), .starts_o(starts), .pin0_i(p0), .pin0_oe_n_i(p0n),
    .pin3_i(p3), .pin3_oe_n_i(p3n), .pad0_o(pad0), .pad3_o(pad3));

  // verdict and end of run
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // compare seen against expected
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer, setup then access until pready
  task automatic xfer(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
    int n;
    apb.psel    <= 1'b1;
    apb.penable <= 1'b0;
    apb.pwrite  <= wr;
    apb.paddr   <= {idx, 2'b00};
    apb.pwdata  <= wd;
    @(posedge clk_i);
    apb.penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      failures++;
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    apb.psel    <= 1'b0;
    apb.penable <= 1'b0;
    @(posedge clk_i);
  endtask

  // write and read-compare helpers
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, {24'h000000, d});
  endtask
  task automatic rdchk(input logic [9:0] idx, input logic [7:0] exp);
    xfer(1'b0, idx, 32'h00000000);
    chk(rd, {24'h000000, exp});
  endtask

  // poll a flag bit under a bounded count
  task automatic wait_flag(input int b);
    int n;
    n = 0;
    do
    begin
      xfer(1'b0, IDX_PFLAG, 32'h00000000);
      n++;
    end
    while (rd[b] !== 1'b1 && n < 100);
    if (n >= 100)
    begin
      failures++;
      report_and_stop();
    end
  endtask

  // timer stopped, count loaded, flags cleared
  task automatic park(input logic [7:0] hi, input logic [7:0] lo);
    wr(IDX_TCTL, 8'h00);
    wr(IDX_CNT_HI, hi);
    wr(IDX_CNT_LO, lo);
    wr(IDX_PFLAG, 8'h00);
  endtask

  // free-running clock
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // main sequence
  initial
  begin
    rst_n_i   = 1'b0;
    apb       = '0;
    ext_clk   = 1'b0;
    failures  = 0;
    tests_run = 0;
    modes = '{MODE_SET, MODE_SWI, MODE_CLR, MODE_SEV, MODE_SET};
    lvl   = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    // reset values and an unmapped place
    rdchk(IDX_PFLAG, RST_PFLAG);
    rdchk(IDX_TCTL, RST_TCTL);
    rdchk(IDX_CCTL, RST_CCTL);
    rdchk(IDX_PDIR, RST_PDIR);
    rdchk(IDX_PIE, RST_PIE);
    xfer(1'b1, 10'h3ff, 32'h000000aa);
    chk(err, 1'b1);
    xfer(1'b0, 10'h3ff, 32'h00000000);
    chk(err, 1'b1);
    chk(rd, 32'h00000000);
    // route to bit 0, make it an output, compare at 5
    wr(IDX_CFG, 8'h00);
    xfer(1'b1, IDX_CFG, 32'h00001000);
    wr(IDX_PDIR, 8'hfe);
    wr(IDX_CMP_LO, 8'h05);
    wr(IDX_CMP_HI, 8'h00);
    wr(IDX_PIE, 8'h04);
    // every compare mode, internal timer source
    for (int i = 0; i < 5; i++)
    begin
      park(8'h00, 8'h00);
      wr(IDX_CCTL, {4'h0, modes[i]});
      wr(IDX_TCTL, 8'h01);
      wait_flag(FLG_CMP);
      chk(irq, 1'b1);
      if (modes[i] == MODE_SEV)
      begin
        chk(starts, 8'h01);
        chk(rd[FLG_OVF], 1'b0);
        wr(IDX_PFLAG, 8'h00);
        wait_flag(FLG_CMP);
        chk(starts, 8'h02);
      end
      else
        chk({p0n, pad0, p3n}, {1'b0, lvl[i], 1'b1});
    end
    // clearing the control register drops the latch
    wr(IDX_CCTL, 8'h00);
    chk(p0, 1'b0);
    // stopped timer sitting on the compare value fires once
    park(8'h00, 8'h00);
    wr(IDX_CCTL, {4'h0, MODE_SWI});
    wr(IDX_CNT_LO, 8'h05);
    wait_flag(FLG_CMP);
    wr(IDX_PFLAG, 8'h00);
    repeat (20) @(posedge clk_i);
    rdchk(IDX_PFLAG, 8'h00);
    rdchk(IDX_CNT_LO, 8'h05);
    // one count per four clocks
    park(8'h00, 8'h00);
    wr(IDX_CCTL, 8'h00);
    wr(IDX_TCTL, 8'h01);
    repeat (40) @(posedge clk_i);
    wr(IDX_TCTL, 8'h00);
    xfer(1'b0, IDX_CNT_LO, 32'h00000000);
    chk(32'(rd[7:0] >= 8'd10 && rd[7:0] <= 8'd13), 32'd1);
    // wrap from all ones sets overflow
    park(8'hff, 8'hfe);
    wr(IDX_TCTL, 8'h01);
    wait_flag(FLG_OVF);
    wr(IDX_TCTL, 8'h00);
    rdchk(IDX_CNT_HI, 8'h00);
    // external source at ratios 1:1 and 1:2, six rising edges each
    for (int p = 0; p < 2; p++)
    begin
      park(8'h00, 8'h00);
      wr(IDX_TCTL, {2'b00, 2'(p), 4'h3});
      repeat (6)
      begin
        ext_clk <= 1'b1;
        repeat (4) @(posedge clk_i);
        ext_clk <= 1'b0;
        repeat (4) @(posedge clk_i);
      end
      wr(IDX_TCTL, 8'h00);
      rdchk(IDX_CNT_LO, 8'(6 >> p));
    end
    // routing to bit 3
    park(8'h00, 8'h00);
    xfer(1'b1, IDX_CFG, 32'h00000000);
    wr(IDX_PDIR, 8'hf7);
    wr(IDX_CCTL, {4'h0, MODE_SET});
    wr(IDX_CNT_LO, 8'h05);
    wait_flag(FLG_CMP);
    chk({p3n, pad3, p0n}, {1'b0, 1'b1, 1'b1});
    // a set flag with its enable cleared raises no request
    wr(IDX_PIE, 8'h00);
    chk(irq, 1'b0);
    report_and_stop();
  end
endmodule
